// >>> rtl/asc_top.sv
/*
 * analog switch control: control register, source combining and
 * registered switch drive for two buffer switches and two throw switches.
 * assumes the serial host decoder delivers a one-cycle write strobe,
 * user pins and pwm are synchronous to clock, and the pin and pwm
 * configuration registers live outside this block.
 */
`timescale 1ns/10ps
`default_nettype none

module asc_top
	import asc_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ctrl_wr_en,
	input wire logic [ASC_REG_W-1:0] ctrl_wr_data,
	output logic [ASC_REG_W-1:0] ctrl_rd_data,
	input wire logic [ASC_NUM_PINS-1:0] user_programmable_pin,
	input wire logic [ASC_NUM_PINS-1:0] pin_active_level,
	input wire logic [ASC_NUM_SW*ASC_NUM_PINS-1:0] user_pin_config,
	input wire logic pwm_level,
	input wire logic first_buffer_pwm_high_enable,
	input wire logic first_buffer_pwm_low_enable,
	input wire logic second_buffer_pwm_high_enable,
	input wire logic second_buffer_pwm_low_enable,
	input wire logic throw_one_pwm_enable,
	input wire logic throw_two_pwm_enable,
	output logic first_buffer_closed,
	output logic second_buffer_closed,
	output logic throw_one_normally_open,
	output logic throw_one_normally_closed,
	output logic throw_two_normally_open,
	output logic throw_two_normally_closed
);
	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	logic [ASC_REG_W-1:0] ctrl_q;
	logic [ASC_REG_W-1:0] ctrl_d;

	// bits 1:0 power up undefined; holding them at zero keeps readback deterministic
	// write stores bits 7:2, unused bits stay zero
	assign ctrl_d = ctrl_wr_en ? (ctrl_wr_data & ASC_CTRL_WMASK) : ctrl_q;

	// register clears at reset
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			ctrl_q <= ASC_CTRL_RESET;
		else
			ctrl_q <= ctrl_d;
	end

	// ----------------------------------------------------------------
	// source combining
	// ----------------------------------------------------------------
	asc_pins_t pin_asserted;
	logic [ASC_NUM_SW-1:0] reg_term;
	logic [ASC_NUM_SW-1:0] pin_term;
	logic [ASC_NUM_SW-1:0] pwm_term;
	logic [ASC_NUM_SW-1:0] sw_term;

	// level bit 1 means high is asserted
	assign pin_asserted = ~(user_programmable_pin ^ pin_active_level);

	// register bit per switch
	assign reg_term[ASC_SW_BUF_A] = ctrl_q[ASC_BIT_BUF_A];
	assign reg_term[ASC_SW_BUF_B] = ctrl_q[ASC_BIT_BUF_B];
	assign reg_term[ASC_SW_T1] = ctrl_q[ASC_BIT_T1_CTL];
	assign reg_term[ASC_SW_T2] = ctrl_q[ASC_BIT_T2_CTL];

	// pwm contribution, zero when not routed
	assign pwm_term[ASC_SW_BUF_A] = (pwm_level & first_buffer_pwm_high_enable)
		| (~pwm_level & first_buffer_pwm_low_enable);
	assign pwm_term[ASC_SW_BUF_B] = (pwm_level & second_buffer_pwm_high_enable)
		| (~pwm_level & second_buffer_pwm_low_enable);
	assign pwm_term[ASC_SW_T1] = pwm_level & throw_one_pwm_enable;
	assign pwm_term[ASC_SW_T2] = pwm_level & throw_two_pwm_enable;

	// per switch: routed pins only, then OR of all sources
	genvar s;
	generate
		for (s = 0; s < ASC_NUM_SW; s++)
		begin : g_sw
			assign pin_term[s] = |(pin_asserted & user_pin_config[s*ASC_NUM_PINS +: ASC_NUM_PINS]);
			assign sw_term[s] = reg_term[s] | pin_term[s] | pwm_term[s];
		end
	endgenerate

	// ----------------------------------------------------------------
	// throw decoders
	// ----------------------------------------------------------------
	asc_throw_if thr_one ();
	asc_throw_if thr_two ();

	// throw one takes bits 5:4, throw two bits 3:2
	assign thr_one.toggle_sel = ctrl_q[ASC_BIT_T1_TOG];
	assign thr_one.control_term = sw_term[ASC_SW_T1];
	assign thr_two.toggle_sel = ctrl_q[ASC_BIT_T2_TOG];
	assign thr_two.control_term = sw_term[ASC_SW_T2];

	// one decoder per double-throw switch, outputs registered below
	asc_throw u_throw_one
	(
		.thr(thr_one.dec)
	);

	asc_throw u_throw_two
	(
		.thr(thr_two.dec)
	);

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	// all switches open and readback zero during reset
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_rd_data <= ASC_CTRL_RESET;
			first_buffer_closed <= 1'b0;
			second_buffer_closed <= 1'b0;
			throw_one_normally_open <= 1'b0;
			throw_one_normally_closed <= 1'b0;
			throw_two_normally_open <= 1'b0;
			throw_two_normally_closed <= 1'b0;
		end
		else
		begin
			ctrl_rd_data <= ctrl_q;
			first_buffer_closed <= sw_term[ASC_SW_BUF_A];
			second_buffer_closed <= sw_term[ASC_SW_BUF_B];
			throw_one_normally_open <= thr_one.close_no;
			throw_one_normally_closed <= thr_one.close_nc;
			throw_two_normally_open <= thr_two.close_no;
			throw_two_normally_closed <= thr_two.close_nc;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	// register path: write lands two edges later, readback trails the register by one
	a_reg_write_load: assert property (ctrl_wr_en
		|-> ##2 ctrl_rd_data == ($past(ctrl_wr_data, 2) & ASC_CTRL_WMASK))
		else $error("control write not visible on readback");

	a_readback_track: assert property (ctrl_rd_data == $past(ctrl_q))
		else $error("readback does not trail the control register");

	a_unused_bits_zero: assert property (ctrl_rd_data[1:0] == 2'b00)
		else $error("unused control bits not zero");

	// buffer switches: any source closes, no source opens
	a_buf_a_or: assert property (ctrl_q[ASC_BIT_BUF_A] |=> first_buffer_closed)
		else $error("buffer A open although its bit is set");

	a_buf_b_or: assert property (ctrl_q[ASC_BIT_BUF_B] |=> second_buffer_closed)
		else $error("buffer B open although its bit is set");

	a_buf_b_open: assert property (!ctrl_q[ASC_BIT_BUF_B] && !(|user_pin_config[7:4])
		&& !second_buffer_pwm_high_enable && !second_buffer_pwm_low_enable |=> !second_buffer_closed)
		else $error("buffer B closed with no source");

	a_pin_level: assert property (user_pin_config[0] && (user_programmable_pin[0] == pin_active_level[0])
		|=> first_buffer_closed)
		else $error("asserted pin did not close buffer A");

	a_pin_b_level: assert property (user_pin_config[4] && (user_programmable_pin[0] == pin_active_level[0])
		|=> second_buffer_closed)
		else $error("asserted pin did not close buffer B");

	a_pwm_a_phase: assert property (!ctrl_q[ASC_BIT_BUF_A] && user_pin_config[3:0] == 4'h0
		|=> first_buffer_closed == (($past(pwm_level) & $past(first_buffer_pwm_high_enable))
		| (~$past(pwm_level) & $past(first_buffer_pwm_low_enable))))
		else $error("buffer A pwm phase wrong");

	a_pwm_b_phase: assert property (!ctrl_q[ASC_BIT_BUF_B] && user_pin_config[7:4] == 4'h0
		|=> second_buffer_closed == (($past(pwm_level) & $past(second_buffer_pwm_high_enable))
		| (~$past(pwm_level) & $past(second_buffer_pwm_low_enable))))
		else $error("buffer B pwm phase wrong");

	// throw switches: together or toggle, term from control bit, pins and pwm
	a_pwm_t1_term: assert property (pwm_level && throw_one_pwm_enable |=> throw_one_normally_open)
		else $error("pwm did not drive throw one");

	a_pwm_t2_term: assert property (pwm_level && throw_two_pwm_enable |=> throw_two_normally_open)
		else $error("pwm did not drive throw two");

	a_throw_together: assert property (!ctrl_q[ASC_BIT_T1_TOG]
		|=> throw_one_normally_open == throw_one_normally_closed)
		else $error("throw one not moving together");

	a_t2_together: assert property (!ctrl_q[ASC_BIT_T2_TOG]
		|=> throw_two_normally_open == throw_two_normally_closed)
		else $error("throw two not moving together");

	a_t1_toggle: assert property (ctrl_q[ASC_BIT_T1_TOG]
		|=> throw_one_normally_open != throw_one_normally_closed)
		else $error("throw one not toggling");

	a_throw_toggle: assert property (ctrl_q[ASC_BIT_T2_TOG]
		|=> throw_two_normally_open != throw_two_normally_closed)
		else $error("throw two not toggling");

	a_t1_term_follow: assert property (ctrl_q[ASC_BIT_T1_CTL] ##1 ctrl_q[ASC_BIT_T1_CTL]
		|-> throw_one_normally_open[*2])
		else $error("throw one control bit ignored");

	a_t2_term_follow: assert property (ctrl_q[ASC_BIT_T2_CTL] ##1 ctrl_q[ASC_BIT_T2_CTL]
		|-> throw_two_normally_open[*2])
		else $error("throw two control bit ignored");

	// main scenarios: pin drive, toggle, pwm drive, pwm low phase, register write
	c_buf_a_by_pin: cover property (!ctrl_q[ASC_BIT_BUF_A] && pin_term[ASC_SW_BUF_A] ##1 first_buffer_closed);
	c_t1_toggle: cover property (ctrl_q[ASC_BIT_T1_TOG] && throw_one_normally_open ##1 throw_one_normally_closed);
	c_t2_pwm: cover property (throw_two_pwm_enable && pwm_level ##1 throw_two_normally_open);
	c_buf_b_low: cover property (second_buffer_pwm_low_enable && !pwm_level ##1 second_buffer_closed);
	c_write: cover property (ctrl_wr_en ##2 ctrl_rd_data == 8'hFC);

endmodule : asc_top

`default_nettype wire

// >>> rtl/asc_pkg.sv
/*
 * constants for the analog switch control block: register layout,
 * reset value, switch indices and pin count.
 * assumes a single 200 MHz clock and an active-low asynchronous reset.
 */
package asc_pkg;

	// ----------------------------------------------------------------
	// register layout
	// ----------------------------------------------------------------
	localparam int unsigned ASC_REG_W = 8;
	localparam logic [7:0] ASC_CTRL_RESET = 8'h00;
	localparam logic [7:0] ASC_CTRL_WMASK = 8'hFC; // bits 1:0 unused
	localparam int unsigned ASC_BIT_BUF_A = 7;
	localparam int unsigned ASC_BIT_BUF_B = 6;
	localparam int unsigned ASC_BIT_T1_TOG = 5;
	localparam int unsigned ASC_BIT_T1_CTL = 4;
	localparam int unsigned ASC_BIT_T2_TOG = 3;
	localparam int unsigned ASC_BIT_T2_CTL = 2;

	// ----------------------------------------------------------------
	// switch and pin indices
	// ----------------------------------------------------------------
	localparam int unsigned ASC_NUM_PINS = 4;
	localparam int unsigned ASC_NUM_SW = 4;
	localparam int unsigned ASC_SW_BUF_A = 0;
	localparam int unsigned ASC_SW_BUF_B = 1;
	localparam int unsigned ASC_SW_T1 = 2;
	localparam int unsigned ASC_SW_T2 = 3;

	typedef logic [ASC_NUM_PINS-1:0] asc_pins_t;

endpackage : asc_pkg

// >>> rtl/asc_throw_if.sv
/*
 * carrier between the switch controller and one double-throw decoder.
 * assumes both ends share the controller's clock domain.
 */
`timescale 1ns/10ps
`default_nettype none

interface asc_throw_if;
	logic toggle_sel;
	logic control_term;
	logic close_no;
	logic close_nc;

	modport ctl
	(
		output toggle_sel,
		output control_term,
		input close_no,
		input close_nc
	);

	modport dec
	(
		input toggle_sel,
		input control_term,
		output close_no,
		output close_nc
	);
endinterface : asc_throw_if

`default_nettype wire

// >>> rtl/asc_throw.sv
/*
 * decoder for one double-throw switch: together or toggle behaviour.
 * assumes the caller registers the outputs.
 */
`timescale 1ns/10ps
`default_nettype none

module asc_throw
	import asc_pkg::*;
(
	asc_throw_if.dec thr
);
	// ----------------------------------------------------------------
	// throw decode
	// ----------------------------------------------------------------
	// together: both follow the term; toggle: complementary pair
	assign thr.close_no = thr.control_term;
	assign thr.close_nc = thr.toggle_sel ? ~thr.control_term : thr.control_term;

endmodule : asc_throw

`default_nettype wire

// >>> verif/asc_switch_model.sv
/*
 * model of the six analog switch elements behind the control block.
 * assumes each drive is a registered level, 1 = closed.
 */
`timescale 1ns/10ps
`default_nettype none

module asc_switch_model
(
	input wire logic [5:0] drive,
	output logic [5:0] conducts
);
	// ----------------------------------------------------------------
	// switch elements
	// ----------------------------------------------------------------
	// an element conducts only while its drive holds it closed
	assign conducts = drive;
endmodule : asc_switch_model

`default_nettype wire

// >>> verif/tb_top.sv
/*
 * self-checking bench for asc_top: reset values, a table of source
 * combinations, then latency and mid-run reset cases.
 * assumes asc_pkg, the design and the switch model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	// ----------------------------------------------------------------
	// signals and table
	// ----------------------------------------------------------------
	logic clock, arst_n, wr_en, pwm;
	logic [7:0] wr_data, rd;
	logic [3:0] pin, lvl;
	logic [15:0] cfg;
	logic [5:0] en, drive, conducts;
	int err_total = 0;
	int checks_done = 0;
	// ctrl, pin, level, routing, pwm, pwm enables, switches {a,b,no1,nc1,no2,nc2}
	localparam logic [44:0] ROWS [0:21] = '{
		{8'h80, 4'h0, 4'h0, 16'h0000, 1'h0, 6'h00, 6'h20},
		{8'h40, 4'h0, 4'h0, 16'h0000, 1'h0, 6'h00, 6'h10},
		{8'h10, 4'h0, 4'h0, 16'h0000, 1'h0, 6'h00, 6'h0C},
		{8'h30, 4'h0, 4'h0, 16'h0000, 1'h0, 6'h00, 6'h08},
		{8'h20, 4'h0, 4'h0, 16'h0000, 1'h0, 6'h00, 6'h04},
		{8'h04, 4'h0, 4'h0, 16'h0000, 1'h0, 6'h00, 6'h03},
		{8'h0C, 4'h0, 4'h0, 16'h0000, 1'h0, 6'h00, 6'h02},
		{8'hFF, 4'h0, 4'h0, 16'h0000, 1'h0, 6'h00, 6'h3A},
		{8'h00, 4'h1, 4'h1, 16'h0001, 1'h0, 6'h00, 6'h20},
		{8'h00, 4'h0, 4'h0, 16'h0010, 1'h0, 6'h00, 6'h10},
		{8'h00, 4'h1, 4'h0, 16'h0010, 1'h0, 6'h00, 6'h00},
		{8'h00, 4'hF, 4'hF, 16'h0000, 1'h0, 6'h00, 6'h00},
		{8'h08, 4'h4, 4'h4, 16'h4000, 1'h0, 6'h00, 6'h02},
		{8'h00, 4'h8, 4'h8, 16'h0800, 1'h0, 6'h00, 6'h0C},
		{8'h00, 4'h0, 4'h0, 16'h0000, 1'h1, 6'h00, 6'h00},
		{8'h00, 4'h0, 4'h0, 16'h0000, 1'h1, 6'h20, 6'h20},
		{8'h00, 4'h0, 4'h0, 16'h0000, 1'h0, 6'h10, 6'h20},
		{8'h00, 4'h0, 4'h0, 16'h0000, 1'h1, 6'h08, 6'h10},
		{8'h00, 4'h0, 4'h0, 16'h0000, 1'h0, 6'h04, 6'h10},
		{8'h00, 4'h0, 4'h0, 16'h0000, 1'h1, 6'h02, 6'h0C},
		{8'h28, 4'h0, 4'h0, 16'h0000, 1'h1, 6'h01, 6'h06},
		{8'h28, 4'h0, 4'h0, 16'h0000, 1'h0, 6'h3E, 6'h35}
	};

	// ----------------------------------------------------------------
	// design and switch model
	// ----------------------------------------------------------------
	asc_top u_asc_top
	(
		.clock(clock), .arst_n(arst_n), .ctrl_wr_en(wr_en), .ctrl_wr_data(wr_data), .ctrl_rd_data(rd),
		.user_programmable_pin(pin), .pin_active_level(lvl), .user_pin_config(cfg), .pwm_level(pwm),
		.first_buffer_pwm_high_enable(en[5]), .first_buffer_pwm_low_enable(en[4]),
		.second_buffer_pwm_high_enable(en[3]), .second_buffer_pwm_low_enable(en[2]),
		.throw_one_pwm_enable(en[1]), .throw_two_pwm_enable(en[0]),
		.first_buffer_closed(drive[5]), .second_buffer_closed(drive[4]),
		.throw_one_normally_open(drive[3]), .throw_one_normally_closed(drive[2]),
		.throw_two_normally_open(drive[1]), .throw_two_normally_closed(drive[0])
	);
	asc_switch_model u_asc_switch_model (.drive(drive), .conducts(conducts));

	// ----------------------------------------------------------------
	// compare and closing tasks
	// ----------------------------------------------------------------
	task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
		end
	endtask : cmp_reg

	task automatic cmp_sw(input logic [5:0] got, input logic [5:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t switches got %h exp %h", $time, got, exp);
		end
	endtask : cmp_sw

	task automatic finish_test;
		if (err_total == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------------
	// clock, watchdog and sequence
	// ----------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// cuts a hang short after far more cycles than the sequence needs
	initial
	begin
		repeat (400) @(posedge clock);
		err_total++;
		finish_test();
	end

	initial
	begin
		arst_n = 1'b0;
		wr_en = 1'b0;
		wr_data = 8'h00;
		pin = 4'h0;
		lvl = 4'h0;
		cfg = 16'h0000;
		pwm = 1'b0;
		en = 6'h00;
		repeat (2) @(posedge clock);
		@(negedge clock);
		cmp_reg(rd, 8'h00);
		cmp_sw(conducts, 6'h00);
		@(posedge clock);
		arst_n <= 1'b1;
		@(negedge clock);
		cmp_reg(rd, 8'h00);
		// table: write the register and apply sources together
		for (int i = 0; i < 22; i++)
		begin
			@(posedge clock);
			{wr_data, pin, lvl, cfg, pwm, en} <= ROWS[i][44:6];
			wr_en <= 1'b1;
			@(posedge clock);
			wr_en <= 1'b0;
			repeat (2) @(posedge clock);
			@(negedge clock);
			cmp_reg(rd, ROWS[i][44:37] & 8'hFC);
			cmp_sw(conducts, ROWS[i][5:0]);
		end
		// pin path answers exactly one cycle after the pin changes
		@(posedge clock);
		en <= 6'h00;
		pin <= 4'h0;
		lvl <= 4'h1;
		cfg <= 16'h0001;
		repeat (2) @(posedge clock);
		pin <= 4'h1;
		@(negedge clock);
		cmp_sw(conducts, 6'h05);
		@(negedge clock);
		cmp_sw(conducts, 6'h25);
		// a reset in mid-run clears the register and opens everything
		@(posedge clock);
		wr_en <= 1'b1;
		wr_data <= 8'hFF;
		cfg <= 16'h0000;
		@(posedge clock);
		wr_en <= 1'b0;
		@(posedge clock);
		// reset lands just after an edge; outputs must drop without waiting for the next one
		@(posedge clock);
		arst_n <= 1'b0;
		#1;
		cmp_reg(rd, 8'h00);
		cmp_sw(conducts, 6'h00);
		// after release the cleared register, not the stored value, must reach the outputs
		@(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		@(negedge clock);
		cmp_reg(rd, 8'h00);
		cmp_sw(conducts, 6'h00);
		finish_test();
	end
endmodule : tb_top

`default_nettype wire
